// ==== design/loader_cmd_regs.vh ====
// constants shared by the loader command unit and its one-time field store
`ifndef LOADER_CMD_REGS_VH
`define LOADER_CMD_REGS_VH

// ****************************************************************
// command codes and parameter totals
// ****************************************************************
`define CALL_CODE            8'h0a
`define CALL_TOTAL           8'h03
`define CHIP_RESET_CODE      8'h0b
`define CHIP_RESET_TOTAL     8'h00
`define OTP_WRITE_CODE       8'h0e
`define OTP_WRITE_TOTAL_4    8'h03
`define OTP_WRITE_TOTAL_8    8'h04
`define OTP_READ_CODE        8'h0f
`define OTP_READ_TOTAL       8'h02
`define MEM_CFG_CODE         8'h11
`define MEM_CFG_TOTAL        8'h02

// ****************************************************************
// reply codes and parameter totals
// ****************************************************************
`define GENERIC_REPLY_CODE   8'ha0
`define GENERIC_REPLY_TOTAL  8'h02
`define OTP_READ_REPLY_CODE  8'haf
`define OTP_READ_REPLY_TOTAL 8'h03

// ****************************************************************
// status words
// ****************************************************************
`define SUCCESS_STATUS       32'h0000_0000
`define INVALID_ARG_STATUS   32'h0000_0069
`define OTP_LOCKED_STATUS    32'h0000_0065
`define OTP_RANGE_STATUS     32'h0000_0066
`define MEM_CFG_FAIL_STATUS  32'h0000_0067
`define UNKNOWN_CMD_STATUS   32'h0000_2711

// ****************************************************************
// byte counts, field store size, executable regions
// ****************************************************************
`define OTP_BYTES_4          32'h0000_0004
`define OTP_BYTES_8          32'h0000_0008
`define OTP_FIELDS           16
`define OTP_INDEX_W          4
`define IFLASH_LO            32'h0000_0000
`define IFLASH_HI            32'h0fff_ffff
`define RAM_LO               32'h2000_0000
`define RAM_HI               32'h2fff_ffff
`define XFLASH_LO            32'h6000_0000
`define XFLASH_HI            32'h7fff_ffff

`endif

// ==== design/loader_misc_command_unit.v ====
// loader command unit: call, chip reset, one-time field write/read, memory configure
`timescale 1ns/10ps
`include "loader_cmd_regs.vh"

module loader_misc_command_unit
#(
   parameter FUSE_VARIANT = 0
)
(
   input  wire         core_clk,
   input  wire         rst_n,
   input  wire         ce,
   input  wire         cmd_valid,
   output wire         cmd_ready,
   input  wire [7:0]   command_code,
   input  wire [7:0]   param_total,
   input  wire [31:0]  cmd_param0,
   input  wire [31:0]  cmd_param1,
   input  wire [31:0]  cmd_param2,
   input  wire [31:0]  cmd_param3,
   input  wire [31:0]  cmd_param4,
   output reg          call_req,
   output reg  [31:0]  call_addr,
   output reg  [31:0]  call_arg,
   input  wire         call_done,
   input  wire [31:0]  call_result,
   output reg          mem_cfg_req,
   output reg  [31:0]  mem_cfg_id,
   output reg  [31:0]  mem_cfg_addr,
   input  wire         mem_cfg_done,
   input  wire         mem_cfg_ok,
   output reg          chip_reset,
   output wire         rsp_valid,
   input  wire         rsp_ready,
   output reg  [7:0]   rsp_code,
   output reg  [7:0]   rsp_total,
   output reg  [31:0]  rsp_status,
   output reg  [31:0]  rsp_word1,
   output reg  [31:0]  rsp_word2,
   output reg  [31:0]  rsp_word3
);

   // ****************************************************************
   // states
   // ****************************************************************
   localparam [5:0] ST_IDLE      = 6'h01;
   localparam [5:0] ST_CALL      = 6'h02;
   localparam [5:0] ST_CFG       = 6'h04;
   localparam [5:0] ST_REPLY     = 6'h08;
   localparam [5:0] ST_RST_REPLY = 6'h10;
   localparam [5:0] ST_RST_HOLD  = 6'h20;

   reg  [5:0]               state;
   reg  [5:0]               next_state;
   reg                      next_call_req;
   reg                      next_cfg_req;
   reg                      next_chip_reset;
   reg                      next_load;
   reg  [7:0]               next_code;
   reg  [7:0]               next_total;
   reg  [31:0]              next_status;
   reg  [31:0]              next_word1;
   reg  [31:0]              next_word2;
   reg  [31:0]              next_word3;
   reg                      otp_wr_en;
   reg                      otp_wide;
   wire [31:0]              otp_lo;
   wire [31:0]              otp_hi;
   wire                     otp_locked;
   wire                     cmd_take;
   wire                     idx_ok;
   wire [`OTP_INDEX_W-1:0]  otp_index;

   // ****************************************************************
   // helpers
   // ****************************************************************
   // true when the address falls in an executable region
   function addr_ok;
      input [31:0] a;
      begin
         addr_ok = (a >= `IFLASH_LO && a <= `IFLASH_HI) ||
                   (a >= `RAM_LO && a <= `RAM_HI) ||
                   (a >= `XFLASH_LO && a <= `XFLASH_HI);
      end
   endfunction

   // byte count legal for this variant; fuse parts take a single word only
   function count_ok;
      input [31:0] n;
      begin
         count_ok = (n == `OTP_BYTES_4) ||
                    (FUSE_VARIANT == 0 && n == `OTP_BYTES_8);
      end
   endfunction

   assign cmd_ready = (state == ST_IDLE);
   assign cmd_take  = ce && cmd_valid && cmd_ready;
   assign rsp_valid = (state == ST_REPLY) || (state == ST_RST_REPLY);
   assign otp_index = cmd_param0[`OTP_INDEX_W-1:0];
   assign idx_ok    = (cmd_param0 < `OTP_FIELDS);

   // ****************************************************************
   // field store
   // ****************************************************************
   otp_field_store u_store
   (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .ce        (ce),
      .wr_en     (otp_wr_en),
      .wr_index  (otp_index),
      .wr_wide   (otp_wide),
      .wr_lo     (cmd_param2),
      .wr_hi     (cmd_param3),
      .rd_index  (otp_index),
      .rd_lo     (otp_lo),
      .rd_hi     (otp_hi),
      .rd_locked (otp_locked)
   );

   // ****************************************************************
   // decode and sequencing
   // ****************************************************************
   // a command is taken only in idle, so one command runs at a time and
   // the parameter ports need only be stable in the taking cycle
   always @*
   begin
      next_state      = state;
      next_call_req   = call_req;
      next_cfg_req    = mem_cfg_req;
      next_chip_reset = chip_reset;
      next_load       = 1'b0;
      next_code       = `GENERIC_REPLY_CODE;
      next_total      = `GENERIC_REPLY_TOTAL;
      next_status     = `SUCCESS_STATUS;
      next_word1      = {24'h000000, command_code};
      next_word2      = 32'h0000_0000;
      next_word3      = 32'h0000_0000;
      otp_wr_en       = 1'b0;
      otp_wide        = 1'b0;
      case (state)
         ST_IDLE:
         begin
            if (cmd_take)
            begin
               next_load  = 1'b1;
               next_state = ST_REPLY;
               case (command_code)
                  `CALL_CODE:
                  begin
                     // the stack word in cmd_param2 is never forwarded
                     if (param_total != `CALL_TOTAL)
                        next_status = `INVALID_ARG_STATUS;
                     else if (!addr_ok(cmd_param0))
                        next_status = `INVALID_ARG_STATUS;
                     else
                     begin
                        next_load     = 1'b0;
                        next_call_req = 1'b1;
                        next_state    = ST_CALL;
                     end
                  end
                  `CHIP_RESET_CODE:
                  begin
                     if (param_total != `CHIP_RESET_TOTAL)
                        next_status = `INVALID_ARG_STATUS;
                     else
                        next_state = ST_RST_REPLY;
                  end
                  `OTP_WRITE_CODE:
                  begin
                     if (param_total != ((cmd_param1 == `OTP_BYTES_8) ?
                                         `OTP_WRITE_TOTAL_8 : `OTP_WRITE_TOTAL_4))
                        next_status = `INVALID_ARG_STATUS;
                     else if (!count_ok(cmd_param1))
                        next_status = `INVALID_ARG_STATUS;
                     else if (!idx_ok)
                        next_status = `OTP_RANGE_STATUS;
                     else if (otp_locked)
                        next_status = `OTP_LOCKED_STATUS;
                     else
                     begin
                        otp_wr_en = 1'b1;
                        otp_wide  = (cmd_param1 == `OTP_BYTES_8);
                     end
                  end
                  `OTP_READ_CODE:
                  begin
                     next_code  = `OTP_READ_REPLY_CODE;
                     next_total = `OTP_READ_REPLY_TOTAL;
                     next_word1 = 32'h0000_0000;
                     if (param_total != `OTP_READ_TOTAL)
                        next_status = `INVALID_ARG_STATUS;
                     else if (!count_ok(cmd_param1))
                        next_status = `INVALID_ARG_STATUS;
                     else if (!idx_ok)
                        next_status = `OTP_RANGE_STATUS;
                     else
                     begin
                        next_word1 = cmd_param1;
                        next_word2 = otp_lo;
                        next_word3 = (cmd_param1 == `OTP_BYTES_8) ? otp_hi : 32'h0000_0000;
                     end
                  end
                  `MEM_CFG_CODE:
                  begin
                     if (param_total != `MEM_CFG_TOTAL)
                        next_status = `INVALID_ARG_STATUS;
                     else
                     begin
                        next_load    = 1'b0;
                        next_cfg_req = 1'b1;
                        next_state   = ST_CFG;
                     end
                  end
                  default:
                     next_status = `UNKNOWN_CMD_STATUS;
               endcase
            end
         end
         ST_CALL:
         begin
            // the called code may take any time; no timeout is applied
            if (ce && call_done)
            begin
               next_call_req = 1'b0;
               next_load     = 1'b1;
               next_word1    = {24'h000000, `CALL_CODE};
               next_status   = call_result;
               next_state    = ST_REPLY;
            end
         end
         ST_CFG:
         begin
            if (ce && mem_cfg_done)
            begin
               next_cfg_req = 1'b0;
               next_load    = 1'b1;
               next_word1   = {24'h000000, `MEM_CFG_CODE};
               next_status  = mem_cfg_ok ? `SUCCESS_STATUS : `MEM_CFG_FAIL_STATUS;
               next_state   = ST_REPLY;
            end
         end
         ST_REPLY:
         begin
            if (ce && rsp_ready)
               next_state = ST_IDLE;
         end
         ST_RST_REPLY:
         begin
            // the reset fires only after the success reply has left
            if (ce && rsp_ready)
            begin
               next_chip_reset = 1'b1;
               next_state      = ST_RST_HOLD;
            end
         end
         ST_RST_HOLD:
            next_state = ST_RST_HOLD;
         default:
            next_state = ST_IDLE;
      endcase
   end

   // ****************************************************************
   // state and output registers
   // ****************************************************************
   // call, configure and reset strobes and reply words come from flip-flops; the field-store write strobe otp_wr_en is combinational
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state        <= ST_IDLE;
         call_req     <= 1'b0;
         call_addr    <= 32'h0000_0000;
         call_arg     <= 32'h0000_0000;
         mem_cfg_req  <= 1'b0;
         mem_cfg_id   <= 32'h0000_0000;
         mem_cfg_addr <= 32'h0000_0000;
         chip_reset   <= 1'b0;
         rsp_code     <= 8'h00;
         rsp_total    <= 8'h00;
         rsp_status   <= 32'h0000_0000;
         rsp_word1    <= 32'h0000_0000;
         rsp_word2    <= 32'h0000_0000;
         rsp_word3    <= 32'h0000_0000;
      end
      else if (ce)
      begin
         state       <= next_state;
         call_req    <= next_call_req;
         mem_cfg_req <= next_cfg_req;
         chip_reset  <= next_chip_reset;
         if (cmd_take)
         begin
            call_addr    <= cmd_param0;
            call_arg     <= cmd_param1;
            mem_cfg_id   <= cmd_param0;
            mem_cfg_addr <= cmd_param1;
         end
         if (next_load)
         begin
            rsp_code   <= next_code;
            rsp_total  <= next_total;
            rsp_status <= next_status;
            rsp_word1  <= next_word1;
            rsp_word2  <= next_word2;
            rsp_word3  <= next_word3;
         end
      end
   end

endmodule // loader_misc_command_unit

// ==== design/otp_field_store.v ====
// one-time field store: flip-flop words with a write-once lock per field
`timescale 1ns/10ps
`include "loader_cmd_regs.vh"

module otp_field_store
(
   input  wire                      core_clk,
   input  wire                      rst_n,
   input  wire                      ce,
   input  wire                      wr_en,
   input  wire [`OTP_INDEX_W-1:0]   wr_index,
   input  wire                      wr_wide,
   input  wire [31:0]               wr_lo,
   input  wire [31:0]               wr_hi,
   input  wire [`OTP_INDEX_W-1:0]   rd_index,
   output wire [31:0]               rd_lo,
   output wire [31:0]               rd_hi,
   output wire                      rd_locked
);

   reg [31:0]              word_lo [0:`OTP_FIELDS-1];
   reg [31:0]              word_hi [0:`OTP_FIELDS-1];
   reg [`OTP_FIELDS-1:0]   locked;
   integer                 i;

   // ****************************************************************
   // storage
   // ****************************************************************
   // an unprogrammed field reads all ones, like an erased cell
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         locked <= {`OTP_FIELDS{1'b0}};
         for (i = 0; i < `OTP_FIELDS; i = i + 1)
         begin
            word_lo[i] <= 32'hffff_ffff;
            word_hi[i] <= 32'hffff_ffff;
         end
      end
      else if (ce && wr_en && !locked[wr_index])
      begin
         locked[wr_index]  <= 1'b1;
         word_lo[wr_index] <= wr_lo;
         if (wr_wide)
            word_hi[wr_index] <= wr_hi;
      end
   end

   // reads are direct; the caller registers what it returns
   assign rd_lo     = word_lo[rd_index];
   assign rd_hi     = word_hi[rd_index];
   assign rd_locked = locked[rd_index];

endmodule // otp_field_store

// ==== tb/exec_model.sv ====
// model of the call executor and external memory configurator
`timescale 1ns/10ps

module exec_model
(
   input  wire        core_clk,
   input  wire        rst_n,
   input  wire [3:0]  exec_delay,
   input  wire        call_req,
   input  wire [31:0] call_addr,
   input  wire [31:0] call_arg,
   output reg         call_done,
   output wire [31:0] call_result,
   input  wire        mem_cfg_req,
   input  wire [31:0] mem_cfg_id,
   output reg         mem_cfg_done,
   output wire        mem_cfg_ok
);
   reg [3:0] cnt;

   // wait exec_delay cycles, then report completion for one cycle
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt <= 4'h0;
         call_done <= 1'b0;
         mem_cfg_done <= 1'b0;
      end
      else if ((call_req || mem_cfg_req) && !call_done && !mem_cfg_done)
      begin
         cnt <= (cnt == exec_delay) ? 4'h0 : cnt + 4'h1;
         call_done <= call_req && cnt == exec_delay;
         mem_cfg_done <= mem_cfg_req && cnt == exec_delay;
      end
      else
      begin
         call_done <= 1'b0;
         mem_cfg_done <= 1'b0;
      end
   end

   // results are only valid with done; otherwise show the inverse, never a stale value
   assign call_result = call_done ? call_addr ^ call_arg : ~(call_addr ^ call_arg);
   assign mem_cfg_ok = mem_cfg_done ~^ (mem_cfg_id != 32'hee);
endmodule // exec_model

// ==== tb/loader_cmd_checker_asserts.sv ====
// concurrent checks on the ports of the loader command unit
`timescale 1ns/10ps
`include "loader_cmd_regs.vh"

module loader_cmd_checker
#(
   parameter FUSE_VARIANT = 0
)
(
   input wire        core_clk,
   input wire        rst_n,
   input wire        ce,
   input wire        cmd_valid,
   input wire        cmd_ready,
   input wire [7:0]  command_code,
   input wire [7:0]  param_total,
   input wire [31:0] cmd_param0,
   input wire [31:0] cmd_param1,
   input wire        call_req,
   input wire [31:0] call_addr,
   input wire [31:0] call_arg,
   input wire        call_done,
   input wire [31:0] call_result,
   input wire        mem_cfg_req,
   input wire [31:0] mem_cfg_id,
   input wire [31:0] mem_cfg_addr,
   input wire        mem_cfg_done,
   input wire        mem_cfg_ok,
   input wire        chip_reset,
   input wire        rsp_valid,
   input wire        rsp_ready,
   input wire [7:0]  rsp_code,
   input wire [7:0]  rsp_total,
   input wire [31:0] rsp_status,
   input wire [31:0] rsp_word1,
   input wire [31:0] rsp_word2
);
   // ****************************************************************
   // helpers
   // ****************************************************************
   // command taken this edge; ce is part of it since low ce freezes all
   wire take = ce && cmd_valid && cmd_ready;
   wire in_region = (cmd_param0 <= `IFLASH_HI) ||
                    (cmd_param0 >= `RAM_LO && cmd_param0 <= `RAM_HI) ||
                    (cmd_param0 >= `XFLASH_LO && cmd_param0 <= `XFLASH_HI);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   // ****************************************************************
   // assertions
   // ****************************************************************
   call_grab_a:
   assert property ($rose(call_req) |-> call_addr == $past(cmd_param0) &&
      call_arg == $past(cmd_param1)) else $error("call operands not captured");
   call_status_a:
   assert property (ce && call_req && call_done |=> rsp_valid &&
      rsp_status == $past(call_result)) else $error("call result not returned");
   call_region_a:
   assert property (take && command_code == `CALL_CODE && param_total == `CALL_TOTAL &&
      !in_region |=> !call_req && rsp_status == `INVALID_ARG_STATUS)
      else $error("call outside regions executed");
   cfg_grab_a:
   assert property ($rose(mem_cfg_req) |-> mem_cfg_id == $past(cmd_param0) &&
      mem_cfg_addr == $past(cmd_param1)) else $error("configure operands wrong");
   cfg_status_a:
   assert property (ce && mem_cfg_req && mem_cfg_done |=> rsp_valid && rsp_status ==
      ($past(mem_cfg_ok) ? `SUCCESS_STATUS : `MEM_CFG_FAIL_STATUS))
      else $error("configure status wrong");
   reset_order_a:
   assert property ($rose(chip_reset) |-> $past(ce) && $past(rsp_valid) &&
      $past(rsp_ready) && $past(rsp_status) == `SUCCESS_STATUS)
      else $error("chip reset before success reply");
   reset_hold_a:
   assert property (chip_reset |=> chip_reset && !cmd_ready && !rsp_valid)
      else $error("chip reset released or unit ready");
   total_check_a:
   assert property (take && command_code == `CHIP_RESET_CODE &&
      param_total != `CHIP_RESET_TOTAL |=> rsp_valid &&
      rsp_status == `INVALID_ARG_STATUS) else $error("bad total not refused");
   read_reply_a:
   assert property (take && command_code == `OTP_READ_CODE && param_total ==
      `OTP_READ_TOTAL |=> rsp_valid && rsp_code == `OTP_READ_REPLY_CODE &&
      rsp_total == `OTP_READ_REPLY_TOTAL) else $error("read reply header wrong");
   read_count_a:
   assert property (take && command_code == `OTP_READ_CODE && param_total ==
      `OTP_READ_TOTAL && cmd_param1 != `OTP_BYTES_4 && (FUSE_VARIANT != 0 ||
      cmd_param1 != `OTP_BYTES_8) |=> rsp_status == `INVALID_ARG_STATUS)
      else $error("read count not refused");
   read_fail_a:
   assert property (rsp_valid && rsp_code == `OTP_READ_REPLY_CODE && rsp_status !=
      `SUCCESS_STATUS |-> rsp_word1 == 32'h0 && rsp_word2 == 32'h0)
      else $error("failed read carries data");

   // main scenarios reached
   cover property (take && command_code == `CALL_CODE);
   cover property ($rose(chip_reset));
   cover property (rsp_valid && rsp_code == `OTP_READ_REPLY_CODE);
endmodule // loader_cmd_checker

bind loader_misc_command_unit loader_cmd_checker #(.FUSE_VARIANT(FUSE_VARIANT)) chk_i (.*);

// ==== tb/test_loader_misc_command_unit.sv ====
// self-checking bench for the loader command unit
`timescale 1ns/10ps
`include "loader_cmd_regs.vh"

module test_loader_misc_command_unit;
   typedef struct {logic [7:0] c, t, rc; logic [31:0] a, b, d, e, s, w1, w2, w3;} row_t;
   logic        core_clk, rst_n, ce, cmd_valid, rsp_ready;
   logic        cmd_ready, call_req, call_done, mem_cfg_req, mem_cfg_done, mem_cfg_ok;
   logic        chip_reset, rsp_valid;
   logic [7:0]  command_code, param_total, rsp_code, rsp_total;
   logic [31:0] cmd_param0, cmd_param1, cmd_param2, cmd_param3, cmd_param4;
   logic [31:0] call_addr, call_arg, call_result, mem_cfg_id, mem_cfg_addr;
   logic [31:0] rsp_status, rsp_word1, rsp_word2, rsp_word3;
   logic [3:0]  exec_delay;
   int          failures, n_compared;
   localparam logic [31:0] z = 32'h0;
   // code, total, reply code, params 0..3, status, words 1..3
   row_t rows [15] = '{
      '{8'h0f, 8'h02, 8'haf, 32'h3, 32'h4, z, z, z, 32'h4, 32'hffff_ffff, z},
      '{8'h0e, 8'h04, 8'ha0, 32'h3, 32'h8, 32'h1111_2222, 32'h3333_4444, z, 32'he, z, z},
      '{8'h0f, 8'h02, 8'haf, 32'h3, 32'h8, z, z, z, 32'h8, 32'h1111_2222, 32'h3333_4444},
      '{8'h0e, 8'h03, 8'ha0, 32'h3, 32'h4, 32'h5, z, 32'h65, 32'he, z, z},
      '{8'h0e, 8'h03, 8'ha0, 32'h5, 32'h8, 32'h5, z, 32'h69, 32'he, z, z},
      '{8'h0e, 8'h03, 8'ha0, 32'h5, 32'h2, 32'h5, z, 32'h69, 32'he, z, z},
      '{8'h0f, 8'h02, 8'haf, 32'h14, 32'h4, z, z, 32'h66, z, z, z},
      '{8'h0f, 8'h02, 8'haf, 32'h3, 32'h5, z, z, 32'h69, z, z, z},
      '{8'h0a, 8'h03, 8'ha0, 32'h2000_0100, 32'h5, 32'hdead_beef, z, 32'h2000_0105,
        32'ha, z, z},
      '{8'h0a, 8'h03, 8'ha0, 32'h4000_0000, 32'h5, z, z, 32'h69, 32'ha, z, z},
      '{8'h0a, 8'h02, 8'ha0, 32'h2000_0100, 32'h5, z, z, 32'h69, 32'ha, z, z},
      '{8'h11, 8'h02, 8'ha0, 32'h1, 32'h2000_1000, z, z, z, 32'h11, z, z},
      '{8'h11, 8'h02, 8'ha0, 32'hee, 32'h2000_1000, z, z, 32'h67, 32'h11, z, z},
      '{8'h3c, 8'h00, 8'ha0, z, z, z, z, 32'h2711, 32'h3c, z, z},
      '{8'h0b, 8'h01, 8'ha0, z, z, z, z, 32'h69, 32'hb, z, z}
   };

   loader_misc_command_unit #(.FUSE_VARIANT(0)) dut (.*);
   exec_model partner (.*);

   // free-running clock, 4 ns period
   always #2 core_clk = ~core_clk;

   // ****************************************************************
   // tasks
   // ****************************************************************
   task automatic close_out;
      if (failures == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // present a command, hold it until taken, then wait for the reply
   task automatic send(input row_t r);
      int k;
      @(negedge core_clk);
      {cmd_valid, command_code, param_total} = {1'b1, r.c, r.t};
      {cmd_param0, cmd_param1, cmd_param2, cmd_param3} = {r.a, r.b, r.d, r.e};
      k = 0;
      while (cmd_ready !== 1'b1 && k < 40)
      begin
         @(negedge core_clk);
         k++;
      end
      if (k >= 40)
      begin
         failures++;
         close_out();
      end
      @(negedge core_clk);
      cmd_valid = 1'b0;
      while (rsp_valid !== 1'b1 && k < 80)
      begin
         @(negedge core_clk);
         k++;
      end
      if (k >= 80)
      begin
         failures++;
         close_out();
      end
   endtask

   // accept the reply; a slow consumer leaves it standing one extra cycle
   task automatic ack;
      @(negedge core_clk);
      rsp_ready = 1'b1;
      @(negedge core_clk);
      rsp_ready = 1'b0;
   endtask

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial
   begin
      {core_clk, rst_n, ce, cmd_valid, rsp_ready, exec_delay} = {3'b001, 2'b00, 4'h0};
      {command_code, param_total, cmd_param0, cmd_param1} = {16'h0, 64'h0};
      {cmd_param2, cmd_param3, cmd_param4, failures, n_compared} = {96'h0, 64'h0};
      repeat (3) @(negedge core_clk);
      rst_n = 1'b1;
      // table of ordinary commands, executor speed varied per row
      for (int i = 0; i < 15; i++)
      begin
         exec_delay = 4'(2 * (i % 8));
         send(rows[i]);
         chk("reply code", {24'h0, rsp_code}, {24'h0, rows[i].rc});
         chk("reply total", {24'h0, rsp_total}, (rows[i].rc == 8'haf) ? 32'h3 : 32'h2);
         chk("status", rsp_status, rows[i].s);
         chk("word1", rsp_word1, rows[i].w1);
         chk("word2", rsp_word2, rows[i].w2);
         chk("word3", rsp_word3, rows[i].w3);
         ack();
      end
      // a low clock enable freezes a standing reply even with the consumer ready
      send(rows[0]);
      ce = 1'b0;
      rsp_ready = 1'b1;
      repeat (2) @(negedge core_clk);
      chk("frozen reply", {31'h0, rsp_valid}, 32'h1);
      rsp_ready = 1'b0;
      ce = 1'b1;
      ack();
      // chip reset: success reply first, reset only after it is accepted
      send('{8'h0b, 8'h00, 8'ha0, z, z, z, z, z, 32'hb, z, z});
      chk("status", rsp_status, `SUCCESS_STATUS);
      chk("early reset", {31'h0, chip_reset}, z);
      ack();
      // the host holds off after a chip reset; the long wait is scaled to cycles here
      repeat (4) @(negedge core_clk);
      chk("chip reset", {31'h0, chip_reset}, 32'h1);
      chk("ready", {31'h0, cmd_ready}, z);
      // reset in mid-run clears the chip reset and reopens the unit
      rst_n = 1'b0;
      @(negedge core_clk);
      chk("reset state", {29'h0, chip_reset, cmd_ready, rsp_valid}, 32'h2);
      rst_n = 1'b1;
      send(rows[8]);
      chk("status", rsp_status, rows[8].s);
      ack();
      close_out();
   end
endmodule // test_loader_misc_command_unit
